/* File: core/dwt_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// three-stage pin synchroniser; level moves only when stages two and three agree
module dwt_pin_sync
  import dwt_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // pin and filtered level
  input wire logic pin_i,
  output logic level_o
);

  logic [2:0] stage_reg;
  logic [2:0] stage_next;
  logic level_reg;
  logic level_next;

  // shift chain; first stage feeds only the second
  always_comb begin
    stage_next = {stage_reg[1:0], pin_i};
    level_next = (stage_reg[1] == stage_reg[2]) ? stage_reg[2] : level_reg;
  end

  // idle bus reads high, so reset to one
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stage_reg <= 3'h7;
      level_reg <= 1'b1;
    end else if (ce_i) begin
      stage_reg <= stage_next;
      level_reg <= level_next;
    end
  end

  assign level_o = level_reg;

endmodule // dwt_pin_sync

`default_nettype wire

/* File: core/dwt_pkg.sv */
package dwt_pkg;

  // serial device address of the threshold page
  localparam logic [6:0] DWT_DEV_ADDR = 7'h51;

  // byte offsets of the threshold pairs
  localparam logic [7:0] DWT_OFS_SUPPLY_LOW_HI = 8'h0e;
  localparam logic [7:0] DWT_OFS_SUPPLY_LOW_LO = 8'h0f;
  localparam logic [7:0] DWT_OFS_BIAS_HIGH_HI = 8'h14;
  localparam logic [7:0] DWT_OFS_BIAS_HIGH_LO = 8'h15;
  localparam logic [7:0] DWT_OFS_BIAS_LOW_HI = 8'h16;
  localparam logic [7:0] DWT_OFS_BIAS_LOW_LO = 8'h17;
  localparam logic [7:0] DWT_OFS_TXPOWER_HIGH_HI = 8'h1c;
  localparam logic [7:0] DWT_OFS_TXPOWER_HIGH_LO = 8'h1d;

  // storage slots in the register array
  localparam int DWT_NUM_THR = 8;
  localparam logic [2:0] DWT_IDX_SUPPLY_LOW_HI = 3'h0;
  localparam logic [2:0] DWT_IDX_SUPPLY_LOW_LO = 3'h1;
  localparam logic [2:0] DWT_IDX_BIAS_HIGH_HI = 3'h2;
  localparam logic [2:0] DWT_IDX_BIAS_HIGH_LO = 3'h3;
  localparam logic [2:0] DWT_IDX_BIAS_LOW_HI = 3'h4;
  localparam logic [2:0] DWT_IDX_BIAS_LOW_LO = 3'h5;
  localparam logic [2:0] DWT_IDX_TXPOWER_HIGH_HI = 3'h6;
  localparam logic [2:0] DWT_IDX_TXPOWER_HIGH_LO = 3'h7;

  // reset and read-back values, pointer step and bit counting constants
  localparam logic [7:0] DWT_THR_RESET = 8'h00;
  localparam logic [7:0] DWT_MEAS_RESET = 8'h00;
  localparam logic [7:0] DWT_UNMAPPED_READ = 8'h00;
  localparam logic [7:0] DWT_PTR_STEP = 8'h01;
  localparam logic [3:0] DWT_BYTE_BITS = 4'h8;
  localparam logic [3:0] DWT_BIT_ONE = 4'h1;

  // weight of one count, kept for software scaling only
  localparam int DWT_SUPPLY_HI_LSB_UV = 25600;
  localparam int DWT_SUPPLY_LO_LSB_UV = 100;
  localparam int DWT_BIAS_LO_LSB_UA = 2;
  localparam int DWT_TXPOWER_HI_LSB_NW = 25600;

  // serial slave states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEVADDR,
    ST_ACK_DEV,
    ST_WR_BYTE,
    ST_ACK_WR,
    ST_RD_BYTE,
    ST_RD_ACK
  } dwt_state_e;

  // offset to {hit, slot}
  function automatic logic [3:0] dwt_decode(input logic [7:0] ofs);
    case (ofs)
      DWT_OFS_SUPPLY_LOW_HI: dwt_decode = {1'b1, DWT_IDX_SUPPLY_LOW_HI};
      DWT_OFS_SUPPLY_LOW_LO: dwt_decode = {1'b1, DWT_IDX_SUPPLY_LOW_LO};
      DWT_OFS_BIAS_HIGH_HI: dwt_decode = {1'b1, DWT_IDX_BIAS_HIGH_HI};
      DWT_OFS_BIAS_HIGH_LO: dwt_decode = {1'b1, DWT_IDX_BIAS_HIGH_LO};
      DWT_OFS_BIAS_LOW_HI: dwt_decode = {1'b1, DWT_IDX_BIAS_LOW_HI};
      DWT_OFS_BIAS_LOW_LO: dwt_decode = {1'b1, DWT_IDX_BIAS_LOW_LO};
      DWT_OFS_TXPOWER_HIGH_HI: dwt_decode = {1'b1, DWT_IDX_TXPOWER_HIGH_HI};
      DWT_OFS_TXPOWER_HIGH_LO: dwt_decode = {1'b1, DWT_IDX_TXPOWER_HIGH_LO};
      default: dwt_decode = 4'h0;
    endcase
  endfunction

  function automatic logic dwt_warn_test(input logic [7:0] meas, input logic [7:0] thr,
                                         input logic above);
    dwt_warn_test = above ? (meas > thr) : (meas < thr);
  endfunction

endpackage

/* File: core/dwt_top.sv */
`timescale 1ns/1ps
`default_nettype none

module dwt_top
  import dwt_pkg::*;
(
  // clock, reset, enable
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // two-wire serial pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // measured high bytes with their strobes
  input wire logic [7:0] measured_supply_hi_i,
  input wire logic measured_supply_stb_i,
  input wire logic [7:0] measured_bias_hi_i,
  input wire logic measured_bias_stb_i,
  input wire logic [7:0] measured_txpower_hi_i,
  input wire logic measured_txpower_stb_i,
  // warning flag bits
  output logic supply_low_warn_o,
  output logic bias_high_warn_o,
  output logic bias_low_warn_o,
  output logic txpower_high_warn_o
);

  // filtered pin levels and their previous values
  logic scl_f;
  logic sda_f;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // serial slave state
  dwt_state_e state_reg;
  dwt_state_e state_next;
  logic [3:0] bit_cnt_reg;
  logic [3:0] bit_cnt_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  logic first_reg;
  logic first_next;
  logic rw_reg;
  logic rw_next;
  logic mst_ack_reg;
  logic mst_ack_next;
  logic oe_reg;
  logic oe_next;
  logic sda_out_reg;

  // threshold storage
  logic [7:0] thr_reg [DWT_NUM_THR];
  logic [7:0] thr_next [DWT_NUM_THR];
  logic [DWT_NUM_THR-1:0] thr_wr;

  // decoded pointer and read data
  logic [3:0] ptr_dec;
  logic [7:0] rd_byte;

  // pin synchronisers
  dwt_pin_sync u_scl_sync (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .pin_i(scl_i),
    .level_o(scl_f)
  );

  dwt_pin_sync u_sda_sync (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .pin_i(sda_i),
    .level_o(sda_f)
  );

  // bus conditions from filtered levels only
  assign scl_rise = scl_f & ~scl_prev_reg;
  assign scl_fall = ~scl_f & scl_prev_reg;
  assign bus_start = scl_f & scl_prev_reg & sda_prev_reg & ~sda_f;
  assign bus_stop = scl_f & scl_prev_reg & ~sda_prev_reg & sda_f;

  // unmapped offsets belong to other blocks and read as zero here
  assign ptr_dec = dwt_decode(ptr_reg);
  assign rd_byte = ptr_dec[3] ? thr_reg[ptr_dec[2:0]] : DWT_UNMAPPED_READ;

  // serial slave and register bank next values
  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    first_next = first_reg;
    rw_next = rw_reg;
    mst_ack_next = mst_ack_reg;
    oe_next = oe_reg;
    thr_wr = '0;
    for (int i = 0; i < DWT_NUM_THR; i++) begin
      thr_next[i] = thr_reg[i];
    end
    if (bus_stop) begin
      // stop ends any transfer and frees the line
      state_next = ST_IDLE;
      oe_next = 1'b0;
    end else if (bus_start) begin
      // start or repeated start; pointer survives for combined reads
      state_next = ST_DEVADDR;
      bit_cnt_next = '0;
      oe_next = 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          oe_next = 1'b0;
        end
        ST_DEVADDR, ST_WR_BYTE: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_f};
            bit_cnt_next = bit_cnt_reg + DWT_BIT_ONE;
          end else if (scl_fall && bit_cnt_reg == DWT_BYTE_BITS) begin
            if (state_reg == ST_DEVADDR) begin
              if (shift_reg[7:1] == DWT_DEV_ADDR) begin
                rw_next = shift_reg[0];
                first_next = ~shift_reg[0];
                oe_next = 1'b1;
                state_next = ST_ACK_DEV;
              end else begin
                state_next = ST_IDLE;
              end
            end else begin
              oe_next = 1'b1;
              state_next = ST_ACK_WR;
              if (first_reg) begin
                // first written byte sets the pointer
                ptr_next = shift_reg;
                first_next = 1'b0;
              end else begin
                ptr_next = ptr_reg + DWT_PTR_STEP;
                if (ptr_dec[3]) begin
                  // supply low byte stored as is
                  // bias low bytes stored as is
                  thr_next[ptr_dec[2:0]] = shift_reg;
                  thr_wr[ptr_dec[2:0]] = 1'b1;
                end
              end
            end
          end
        end
        ST_ACK_DEV: begin
          if (scl_fall) begin
            bit_cnt_next = '0;
            if (rw_reg) begin
              shift_next = rd_byte;
              oe_next = ~rd_byte[7];
              state_next = ST_RD_BYTE;
            end else begin
              oe_next = 1'b0;
              state_next = ST_WR_BYTE;
            end
          end
        end
        ST_ACK_WR: begin
          if (scl_fall) begin
            bit_cnt_next = '0;
            oe_next = 1'b0;
            state_next = ST_WR_BYTE;
          end
        end
        ST_RD_BYTE: begin
          if (scl_rise) begin
            bit_cnt_next = bit_cnt_reg + DWT_BIT_ONE;
          end else if (scl_fall) begin
            if (bit_cnt_reg == DWT_BYTE_BITS) begin
              // release for the host's acknowledge
              oe_next = 1'b0;
              ptr_next = ptr_reg + DWT_PTR_STEP;
              state_next = ST_RD_ACK;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              oe_next = ~shift_reg[6];
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            mst_ack_next = ~sda_f;
          end else if (scl_fall) begin
            bit_cnt_next = '0;
            if (mst_ack_reg) begin
              shift_next = rd_byte;
              oe_next = ~rd_byte[7];
              state_next = ST_RD_BYTE;
            end else begin
              // not acknowledged: host ends the read
              state_next = ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // slave state registers; all freeze while ce_i is low
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      state_reg <= ST_IDLE;
      bit_cnt_reg <= '0;
      shift_reg <= '0;
      ptr_reg <= '0;
      first_reg <= 1'b0;
      rw_reg <= 1'b0;
      mst_ack_reg <= 1'b0;
      oe_reg <= 1'b0;
      sda_out_reg <= 1'b0;
    end else if (ce_i) begin
      scl_prev_reg <= scl_f;
      sda_prev_reg <= sda_f;
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      first_reg <= first_next;
      rw_reg <= rw_next;
      mst_ack_reg <= mst_ack_next;
      oe_reg <= oe_next;
      sda_out_reg <= 1'b0;
    end
  end

  // threshold array
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < DWT_NUM_THR; i++) begin
        thr_reg[i] <= DWT_THR_RESET;
      end
    end else if (ce_i) begin
      for (int i = 0; i < DWT_NUM_THR; i++) begin
        thr_reg[i] <= thr_next[i];
      end
    end
  end

  // open-drain: only ever pulls low
  assign sda_o = sda_out_reg;
  assign sda_oe_o = oe_reg;

  dwt_warn_cmp #(.ABOVE(1'b0)) u_supply_low (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .meas_stb_i(measured_supply_stb_i),
    .meas_i(measured_supply_hi_i),
    .thr_wr_i(thr_wr[DWT_IDX_SUPPLY_LOW_HI]),
    .thr_i(thr_next[DWT_IDX_SUPPLY_LOW_HI]),
    .warn_o(supply_low_warn_o)
  );

  dwt_warn_cmp #(.ABOVE(1'b1)) u_bias_high (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .meas_stb_i(measured_bias_stb_i),
    .meas_i(measured_bias_hi_i),
    .thr_wr_i(thr_wr[DWT_IDX_BIAS_HIGH_HI]),
    .thr_i(thr_next[DWT_IDX_BIAS_HIGH_HI]),
    .warn_o(bias_high_warn_o)
  );

  dwt_warn_cmp #(.ABOVE(1'b0)) u_bias_low (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .meas_stb_i(measured_bias_stb_i),
    .meas_i(measured_bias_hi_i),
    .thr_wr_i(thr_wr[DWT_IDX_BIAS_LOW_HI]),
    .thr_i(thr_next[DWT_IDX_BIAS_LOW_HI]),
    .warn_o(bias_low_warn_o)
  );

  dwt_warn_cmp #(.ABOVE(1'b1)) u_txpower_high (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .meas_stb_i(measured_txpower_stb_i),
    .meas_i(measured_txpower_hi_i),
    .thr_wr_i(thr_wr[DWT_IDX_TXPOWER_HIGH_HI]),
    .thr_i(thr_next[DWT_IDX_TXPOWER_HIGH_HI]),
    .warn_o(txpower_high_warn_o)
  );

endmodule // dwt_top

`default_nettype wire

/* File: core/dwt_warn_cmp.sv */
`timescale 1ns/1ps
`default_nettype none

// one warning comparison: holds the last measured high byte and the flag
module dwt_warn_cmp
  import dwt_pkg::*;
#(
  parameter bit ABOVE = 1'b1
)
(
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // measurement side
  input wire logic meas_stb_i,
  input wire logic [7:0] meas_i,
  // threshold side, value as it will be after this edge
  input wire logic thr_wr_i,
  input wire logic [7:0] thr_i,
  // flag
  output logic warn_o
);

  logic [7:0] meas_reg;
  logic [7:0] meas_next;
  logic warn_reg;
  logic warn_next;

  // a fresh measurement wins over the stored one in the same cycle
  always_comb begin
    meas_next = meas_stb_i ? meas_i : meas_reg;
    warn_next = warn_reg;
    if (meas_stb_i || thr_wr_i) begin
      warn_next = dwt_warn_test(meas_next, thr_i, ABOVE);
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meas_reg <= DWT_MEAS_RESET;
      warn_reg <= 1'b0;
    end else if (ce_i) begin
      meas_reg <= meas_next;
      warn_reg <= warn_next;
    end
  end

  assign warn_o = warn_reg;

endmodule // dwt_warn_cmp

`default_nettype wire

/* File: sim/dwt_host.sv */
`timescale 1ns/1ps
`default_nettype none

// bus host: drives the clock pin and pulls the data wire low
module dwt_host (
  // clock
  input wire logic clock_i,
  // serial wire
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // one bus phase; the slave filter needs at least 4 clocks
  localparam int HALF = 10;

  // bus idle: clock high, data released
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // wait one phase, then set both pins; callers change only one
  task automatic ph(input logic s, input logic d);
    repeat (HALF) @(posedge clock_i);
    scl_o <= s;
    sda_low_o <= d;
  endtask

  // data changes only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    ph(1'b0, !b);
    ph(1'b1, !b);
    repeat (HALF) @(posedge clock_i);
    r = sda_i;
    scl_o <= 1'b0;
  endtask

  // start or repeated start
  task automatic start();
    ph(scl_o, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
    ph(1'b0, 1'b1);
  endtask

  // stop leaves the bus idle
  task automatic stop();
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
    repeat (HALF) @(posedge clock_i);
  endtask

  // eight bits and the acknowledge slot, most significant first
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
  endtask

  // select the page, then offset and data
  task automatic wr(input logic [6:0] a, input logic [7:0] o, input logic [7:0] d, output logic ok);
    logic [8:0] q0, q1, q2;
    start();
    xfer({a, 1'b0, 1'b1}, q0);
    xfer({o, 1'b1}, q1);
    xfer({d, 1'b1}, q2);
    stop();
    ok = !(q0[0] | q1[0] | q2[0]);
  endtask

  // pointer write, repeated start, one byte refused at the end
  task automatic rd(input logic [6:0] a, input logic [7:0] o, output logic [7:0] d, output logic ok);
    logic [8:0] q0, q1, q2, q3;
    start();
    xfer({a, 1'b0, 1'b1}, q0);
    xfer({o, 1'b1}, q1);
    start();
    xfer({a, 1'b1, 1'b1}, q2);
    xfer({8'hff, 1'b1}, q3);
    stop();
    d = q3[8:1];
    ok = !(q0[0] | q1[0] | q2[0]);
  endtask
endmodule // dwt_host

`default_nettype wire

/* File: sim/dwt_top_chk.sv */
`timescale 1ns/1ps
`default_nettype none

// port watcher for the warning threshold bank
module dwt_top_chk (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // serial pins
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  // measurements
  input wire logic [7:0] measured_bias_hi_i,
  input wire logic measured_bias_stb_i,
  input wire logic [7:0] measured_supply_hi_i,
  input wire logic measured_supply_stb_i,
  input wire logic [7:0] measured_txpower_hi_i,
  input wire logic measured_txpower_stb_i,
  // flags
  input wire logic supply_low_warn_o,
  input wire logic bias_high_warn_o,
  input wire logic bias_low_warn_o,
  input wire logic txpower_high_warn_o
);
  logic scl_q_reg;
  logic [3:0] age_reg;
  logic [3:0] age_next;

  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  // clocks since the clock pin fell; a threshold write lands a few clocks later
  always_comb begin
    age_next = (age_reg == 4'hf) ? age_reg : age_reg + 4'h1;
    if (scl_q_reg && !scl_i) begin
      age_next = 4'h0;
    end
  end

  // saturates so an idle bus never wraps back into the window
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_q_reg <= 1'b1;
      age_reg <= 4'hf;
    end else begin
      scl_q_reg <= scl_i;
      age_reg <= age_next;
    end
  end

  // event steps that may move a flag; a frozen block takes no strobe
  sequence bias_zero_s;
    ce_i && measured_bias_stb_i && measured_bias_hi_i == 8'h00;
  endsequence
  sequence bias_full_s;
    ce_i && measured_bias_stb_i && measured_bias_hi_i == 8'hff;
  endsequence
  sequence supply_event_s;
    $past(measured_supply_stb_i) || age_reg <= 4'h8;
  endsequence

  a_reset_flags_clear: assert property ($rose(nrst_i) |->
    !(supply_low_warn_o || bias_high_warn_o || bias_low_warn_o || txpower_high_warn_o))
    else $error("flag set after reset");
  a_reset_bus_idle: assert property ($rose(nrst_i) |-> !sda_oe_o)
    else $error("data pin pulled after reset");
  a_sda_value_low: assert property (sda_o == 1'b0)
    else $error("data value not low");
  a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data pin moved while clock high");
  a_bias_zero_clear: assert property (bias_zero_s |=> !bias_high_warn_o)
    else $error("bias high flag on zero reading");
  a_bias_full_clear: assert property (bias_full_s |=> !bias_low_warn_o)
    else $error("bias low flag on full reading");
  a_tx_zero_clear: assert property (ce_i && measured_txpower_stb_i && measured_txpower_hi_i == 8'h00
    |=> !txpower_high_warn_o) else $error("power flag on zero reading");
  a_supply_full_clear: assert property (ce_i && measured_supply_stb_i && measured_supply_hi_i == 8'hff
    |=> !supply_low_warn_o) else $error("supply flag on full reading");
  a_supply_event_only: assert property ($changed(supply_low_warn_o) |-> supply_event_s)
    else $error("supply flag moved without an event");
endmodule // dwt_top_chk

bind dwt_top dwt_top_chk u_dwt_top_chk (
  .clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .measured_bias_hi_i(measured_bias_hi_i), .measured_bias_stb_i(measured_bias_stb_i),
  .measured_supply_hi_i(measured_supply_hi_i), .measured_supply_stb_i(measured_supply_stb_i),
  .measured_txpower_hi_i(measured_txpower_hi_i), .measured_txpower_stb_i(measured_txpower_stb_i),
  .supply_low_warn_o(supply_low_warn_o), .bias_high_warn_o(bias_high_warn_o),
  .bias_low_warn_o(bias_low_warn_o), .txpower_high_warn_o(txpower_high_warn_o)
);

`default_nettype wire

/* File: sim/dwt_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module dwt_top_tb;
  import dwt_pkg::*;
  logic clock_i, nrst_i, scl, host_low, ok, s_stb, b_stb, t_stb, sda_o, sda_oe, ce;
  logic [7:0] s_hi, b_hi, t_hi, d;
  logic [3:0] warn;
  wire logic sda_w;
  int err_count, checks_done;
  // offset, threshold, measurement, expected flag
  logic [31:0] rows [14] = '{32'h0e403f01, 32'h0e404000, 32'h0e404100, 32'h14404101, 32'h14404000,
    32'h16403f01, 32'h16404100, 32'h1c7f8001, 32'h1c807f00, 32'h1cffff00, 32'h14000000,
    32'h1c000000, 32'h0effff00, 32'h16ffff00};
  logic [7:0] offs [8] = '{8'h0e, 8'h0f, 8'h14, 8'h15, 8'h16, 8'h17, 8'h1c, 8'h1d};
  logic [7:0] lows [2] = '{8'h0e, 8'h16};

  // open-drain wire with its pull-up
  assign sda_w = !(host_low || sda_oe);

  dwt_host u_dwt_host (.clock_i(clock_i), .sda_i(sda_w), .scl_o(scl), .sda_low_o(host_low));

  dwt_top u_dwt_top (
    .clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .measured_supply_hi_i(s_hi), .measured_supply_stb_i(s_stb),
    .measured_bias_hi_i(b_hi), .measured_bias_stb_i(b_stb), .measured_txpower_hi_i(t_hi),
    .measured_txpower_stb_i(t_stb), .supply_low_warn_o(warn[3]), .bias_high_warn_o(warn[2]),
    .bias_low_warn_o(warn[1]), .txpower_high_warn_o(warn[0])
  );

  // 100 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // flag that belongs to a threshold offset
  function automatic logic [7:0] flag(input logic [7:0] o);
    flag = {7'h0, warn[(o == 8'h0e) ? 3 : (o == 8'h14) ? 2 : (o == 8'h16) ? 1 : 0]};
  endfunction

  // one strobe for the channel of an offset; bias feeds both bias flags
  task automatic pulse(input logic [7:0] o, input logic [7:0] m);
    @(posedge clock_i);
    {s_hi, b_hi, t_hi} <= {m, m, m};
    {s_stb, b_stb, t_stb} <= {o == 8'h0e, o == 8'h14 || o == 8'h16, o == 8'h1c};
    @(posedge clock_i);
    {s_stb, b_stb, t_stb} <= 3'b000;
    #1;
  endtask

  // watchdog; the tests take about 62k clocks
  initial begin
    repeat (90000) @(posedge clock_i);
    err_count++;
    end_sim();
  end

  // main sequence
  initial begin
    {nrst_i, s_stb, b_stb, t_stb} = 4'h0;
    ce = 1'b1;
    {s_hi, b_hi, t_hi} = 24'h0;
    repeat (4) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    chk({4'h0, warn}, 8'h00);
    foreach (offs[i]) begin
      u_dwt_host.rd(DWT_DEV_ADDR, offs[i], d, ok);
      chk(d, 8'h00);
    end
    foreach (rows[i]) begin
      u_dwt_host.wr(DWT_DEV_ADDR, rows[i][31:24], rows[i][23:16], ok);
      u_dwt_host.wr(DWT_DEV_ADDR, rows[i][31:24] + 8'h01, 8'h00, ok);
      pulse(rows[i][31:24], rows[i][15:8]);
      chk(flag(rows[i][31:24]), rows[i][7:0]);
    end
    foreach (offs[i]) begin
      u_dwt_host.wr(DWT_DEV_ADDR, offs[i], 8'h5a ^ offs[i], ok);
    end
    foreach (offs[i]) begin
      u_dwt_host.rd(DWT_DEV_ADDR, offs[i], d, ok);
      chk(d, 8'h5a ^ offs[i]);
      chk({7'h0, ok}, 8'h01);
    end
    // full-scale low byte would warn if it took part
    foreach (lows[i]) begin
      u_dwt_host.wr(DWT_DEV_ADDR, lows[i] + 8'h01, 8'hff, ok);
      u_dwt_host.wr(DWT_DEV_ADDR, lows[i], 8'h40, ok);
      pulse(lows[i], 8'h40);
      chk(flag(lows[i]), 8'h00);
    end
    // threshold write alone moves the flag
    u_dwt_host.wr(DWT_DEV_ADDR, 8'h14, 8'h40, ok);
    pulse(8'h14, 8'h50);
    chk({7'h0, warn[2]}, 8'h01);
    u_dwt_host.wr(DWT_DEV_ADDR, 8'h14, 8'h60, ok);
    chk({7'h0, warn[2]}, 8'h00);
    // foreign address, unmapped offset
    u_dwt_host.wr(7'h50, 8'h14, 8'h00, ok);
    chk({7'h0, ok}, 8'h00);
    u_dwt_host.wr(DWT_DEV_ADDR, 8'h10, 8'h55, ok);
    chk({7'h0, ok}, 8'h01);
    u_dwt_host.rd(DWT_DEV_ADDR, 8'h10, d, ok);
    chk(d, 8'h00);
    u_dwt_host.rd(DWT_DEV_ADDR, 8'h14, d, ok);
    chk(d, 8'h60);
    pulse(8'h14, 8'h70);
    chk({7'h0, warn[2]}, 8'h01);
    // enable low freezes the flag through a clearing reading
    @(posedge clock_i);
    ce <= 1'b0;
    pulse(8'h14, 8'h00);
    chk({7'h0, warn[2]}, 8'h01);
    @(posedge clock_i);
    ce <= 1'b1;
    // reset in mid-run with the flag still raised
    @(posedge clock_i);
    nrst_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    chk({4'h0, warn}, 8'h00);
    u_dwt_host.rd(DWT_DEV_ADDR, 8'h14, d, ok);
    chk(d, 8'h00);
    end_sim();
  end
endmodule // dwt_top_tb

`default_nettype wire
